/* gpio_pin_config_debounce.sv */
// GPIO pad control, live input status, output stage select and switch debounce.
// Assumes a byte register port from a protocol engine and synchronous pad inputs.
module gpio_pin_config_debounce
    import gpio_cfg_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             arst_n,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    output logic      [7:0]       reg_rdata,
    input  wire logic [PIN_N-1:0] pin_dir_out,
    input  wire logic [PIN_N-1:0] pin_out_level,
    input  wire logic [PIN_N-1:0] pull_enable,
    input  wire logic [PIN_N-1:0] pull_select_up,
    input  wire logic [PIN_N-1:0] pad_in,
    output logic      [PIN_N-1:0] pad_out,
    output logic      [PIN_N-1:0] pad_oe,
    output logic      [PIN_N-1:0] pad_pull_up_en,
    output logic      [PIN_N-1:0] pad_pull_dn_en,
    output logic      [PIN_N-1:0] pad_in_buf_en,
    output logic      [PIN_N-1:0] pin_filtered
);

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    logic [BANK_DRAIN_W-1:0] bank_drain_reg;
    logic [BANK_DRAIN_W-1:0] bank_drain_next;
    logic [PIN_N-1:0]        stage_ovr_reg;
    logic [PIN_N-1:0]        stage_ovr_next;
    logic [DB_PINS-1:0]      debounce_en_reg;
    logic [DB_PINS-1:0]      debounce_en_next;
    logic [7:0]              debounce_cnt_reg;
    logic [7:0]              debounce_cnt_next;
    logic [7:0]              rdata_reg;
    logic [7:0]              rdata_next;

    logic [PIN_N-1:0]        open_drain;
    logic [PIN_N-1:0]        live_status;

    // Reset drops all accesses, so writes need no gating here
    always_comb begin
        bank_drain_next   = bank_drain_reg;
        stage_ovr_next    = stage_ovr_reg;
        debounce_en_next  = debounce_en_reg;
        debounce_cnt_next = debounce_cnt_reg;
        if (reg_wr) begin
            case (reg_addr)
                ADDR_BANK_DRAIN:   bank_drain_next = reg_wdata[BANK_DRAIN_W-1:0];
                ADDR_STAGE_OVR0:   stage_ovr_next[7:0] = reg_wdata;
                ADDR_STAGE_OVR1:   stage_ovr_next[15:8] = reg_wdata;
                ADDR_STAGE_OVR2:   stage_ovr_next[23:16] = reg_wdata;
                ADDR_DEBOUNCE_EN0: debounce_en_next[7:0] = reg_wdata;
                ADDR_DEBOUNCE_EN1: debounce_en_next[15:8] = reg_wdata;
                ADDR_DEBOUNCE_CNT: debounce_cnt_next = reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // Read data; live registers are pure views, no side effects
    always_comb begin
        rdata_next = rdata_reg;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_BANK_DRAIN:   rdata_next = {5'h00, bank_drain_reg};
                ADDR_LIVE_IN0:     rdata_next = live_status[7:0];
                ADDR_LIVE_IN1:     rdata_next = live_status[15:8];
                ADDR_LIVE_IN2:     rdata_next = live_status[23:16];
                ADDR_STAGE_OVR0:   rdata_next = stage_ovr_reg[7:0];
                ADDR_STAGE_OVR1:   rdata_next = stage_ovr_reg[15:8];
                ADDR_STAGE_OVR2:   rdata_next = stage_ovr_reg[23:16];
                ADDR_DEBOUNCE_EN0: rdata_next = debounce_en_reg[7:0];
                ADDR_DEBOUNCE_EN1: rdata_next = debounce_en_reg[15:8];
                ADDR_DEBOUNCE_CNT: rdata_next = debounce_cnt_reg;
                default:           rdata_next = UNMAPPED_RDATA;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            bank_drain_reg   <= BANK_DRAIN_RST;
            stage_ovr_reg    <= {NUM_PORT{STAGE_OVR_RST}};
            debounce_en_reg  <= {2{DEBOUNCE_EN_RST}};
            debounce_cnt_reg <= DEBOUNCE_CNT_RST;
            rdata_reg        <= UNMAPPED_RDATA;
        end else begin
            bank_drain_reg   <= bank_drain_next;
            stage_ovr_reg    <= stage_ovr_next;
            debounce_en_reg  <= debounce_en_next;
            debounce_cnt_reg <= debounce_cnt_next;
            rdata_reg        <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // ----------------------------------------
    // Pad control per pin
    // ----------------------------------------
    logic [PIN_N-1:0] pad_out_next;
    logic [PIN_N-1:0] pad_oe_next;
    logic [PIN_N-1:0] pull_up_next;
    logic [PIN_N-1:0] pull_dn_next;
    logic [PIN_N-1:0] in_buf_next;

    genvar gp;
    generate
        for (gp = 0; gp < PIN_N; gp++) begin : g_pad
            // Override bit flips the bank choice for this pin only
            assign open_drain[gp] = bank_drain_reg[gp / PORT_W] ^ stage_ovr_reg[gp];
            assign live_status[gp] = (pin_dir_out[gp] && open_drain[gp]) ? 1'b0
                                                                          : pad_in[gp];
            always_comb begin
                if (pin_dir_out[gp]) begin
                    if (open_drain[gp]) begin
                        pad_out_next[gp] = 1'b0;
                        pad_oe_next[gp]  = ~pin_out_level[gp];
                    end else begin
                        pad_out_next[gp] = pin_out_level[gp];
                        pad_oe_next[gp]  = 1'b1;
                    end
                end else begin
                    pad_out_next[gp] = 1'b0;
                    pad_oe_next[gp]  = 1'b0;
                end
                pull_up_next[gp] = pull_enable[gp] & pull_select_up[gp];
                pull_dn_next[gp] = pull_enable[gp] & ~pull_select_up[gp];
                in_buf_next[gp]  = ~pin_dir_out[gp];
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pad_out        <= '0;
            pad_oe         <= '0;
            pad_pull_up_en <= '0;
            pad_pull_dn_en <= '0;
            pad_in_buf_en  <= '1;
        end else begin
            pad_out        <= pad_out_next;
            pad_oe         <= pad_oe_next;
            pad_pull_up_en <= pull_up_next;
            pad_pull_dn_en <= pull_dn_next;
            pad_in_buf_en  <= in_buf_next;
        end
    end

    // ----------------------------------------
    // Debounce time base and cells
    // ----------------------------------------
    logic             timebase_ok;
    logic             timebase_last_reg;
    logic             timebase_last_next;
    logic             timebase_tick;
    logic [DB_PINS-1:0] db_settled;
    logic [DB_PINS-1:0] db_active;
    logic [PIN_N-1:0] filtered_next;

    assign timebase_ok = ~pin_dir_out[TIMEBASE_PIN] & debounce_en_reg[TIMEBASE_PIN];
    assign timebase_last_next = pad_in[TIMEBASE_PIN];
    assign timebase_tick = timebase_ok & pad_in[TIMEBASE_PIN] & ~timebase_last_reg;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            timebase_last_reg <= 1'b0;
        end else begin
            timebase_last_reg <= timebase_last_next;
        end
    end

    assign db_active[TIMEBASE_PIN] = 1'b0;
    assign db_settled[TIMEBASE_PIN] = pad_in[TIMEBASE_PIN];

    genvar gd;
    generate
        for (gd = 1; gd < DB_PINS; gd++) begin : g_db
            assign db_active[gd] = timebase_ok & debounce_en_reg[gd] & ~pin_dir_out[gd];
            debounce_cell u_cell (
                .core_clk (core_clk),
                .arst_n   (arst_n),
                .active   (db_active[gd]),
                .tick     (timebase_tick),
                .pin      (pad_in[gd]),
                .period   (debounce_cnt_reg),
                .settled  (db_settled[gd])
            );
        end
    endgenerate

    always_comb begin
        filtered_next = pad_in;
        filtered_next[DB_PINS-1:0] = (db_active & db_settled)
                                   | (~db_active & pad_in[DB_PINS-1:0]);
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_filtered <= '1;
        end else begin
            pin_filtered <= filtered_next;
        end
    end

endmodule

/* gpio_cfg_pkg.sv */
// Register map, field positions and reset values of the GPIO pin block.
// Assumes a single core clock domain and byte-wide register access.
package gpio_cfg_pkg;

    // ----------------------------------------
    // Geometry
    // ----------------------------------------
    localparam int PORT_W   = 8;
    localparam int NUM_PORT = 3;
    localparam int PIN_N    = PORT_W * NUM_PORT;
    localparam int DB_PINS  = 16;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_BANK_DRAIN    = 8'h5c;
    localparam logic [7:0] ADDR_LIVE_IN0      = 8'h6c;
    localparam logic [7:0] ADDR_LIVE_IN1      = 8'h6d;
    localparam logic [7:0] ADDR_LIVE_IN2      = 8'h6e;
    localparam logic [7:0] ADDR_STAGE_OVR0    = 8'h70;
    localparam logic [7:0] ADDR_STAGE_OVR1    = 8'h71;
    localparam logic [7:0] ADDR_STAGE_OVR2    = 8'h72;
    localparam logic [7:0] ADDR_DEBOUNCE_EN0  = 8'h74;
    localparam logic [7:0] ADDR_DEBOUNCE_EN1  = 8'h75;
    localparam logic [7:0] ADDR_DEBOUNCE_CNT  = 8'h76;

    // ----------------------------------------
    // Fields and reset values
    // ----------------------------------------
    localparam int         BANK_DRAIN_W       = 3;
    localparam int         TIMEBASE_PIN       = 0;
    localparam logic [2:0] BANK_DRAIN_RST     = 3'h0;
    localparam logic [7:0] STAGE_OVR_RST      = 8'h00;
    localparam logic [7:0] DEBOUNCE_EN_RST    = 8'h00;
    localparam logic [7:0] DEBOUNCE_CNT_RST   = 8'h00;
    localparam logic [7:0] UNMAPPED_RDATA     = 8'h00;

endpackage

/* debounce_cell.sv */
// One switch debouncer: qualifies a pin level over a count of time-base ticks.
// Assumes the tick is a one-cycle pulse in the core clock domain.
module debounce_cell
    import gpio_cfg_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    input  wire logic       active,
    input  wire logic       tick,
    input  wire logic       pin,
    input  wire logic [7:0] period,
    output logic            settled
);

    logic       last_reg;
    logic       last_next;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic       settled_reg;
    logic       settled_next;

    // ----------------------------------------
    // Qualification
    // ----------------------------------------
    always_comb begin
        last_next    = pin;
        cnt_next     = cnt_reg;
        settled_next = settled_reg;
        if (!active) begin
            cnt_next     = 8'h00;
            settled_next = pin;
        end else if (pin != last_reg) begin
            // Edge restarts the qualification period
            cnt_next = 8'h00;
        end else if (tick) begin
            if (cnt_reg >= period) begin
                settled_next = last_reg;
                cnt_next     = 8'h00;
            end else begin
                cnt_next = cnt_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            last_reg    <= 1'b1;
            cnt_reg     <= 8'h00;
            settled_reg <= 1'b1;
        end else begin
            last_reg    <= last_next;
            cnt_reg     <= cnt_next;
            settled_reg <= settled_next;
        end
    end

    assign settled = settled_reg;

endmodule

/* gpio_pin_sva.sv */
// Assertion checker for the GPIO pin block, bound to its top module.
// Assumes one core clock domain and the asynchronous active-low reset.
module gpio_pin_sva
    import gpio_cfg_pkg::*;
(
    input wire logic             core_clk,
    input wire logic             arst_n,
    input wire logic             reg_wr,
    input wire logic             reg_rd,
    input wire logic [7:0]       reg_addr,
    input wire logic [7:0]       reg_wdata,
    input wire logic [7:0]       reg_rdata,
    input wire logic [PIN_N-1:0] pin_dir_out,
    input wire logic [PIN_N-1:0] pin_out_level,
    input wire logic [PIN_N-1:0] pull_enable,
    input wire logic [PIN_N-1:0] pull_select_up,
    input wire logic [PIN_N-1:0] pad_in,
    input wire logic [PIN_N-1:0] pad_out,
    input wire logic [PIN_N-1:0] pad_oe,
    input wire logic [PIN_N-1:0] pad_pull_up_en,
    input wire logic [PIN_N-1:0] pad_pull_dn_en,
    input wire logic [PIN_N-1:0] pad_in_buf_en,
    input wire logic [PIN_N-1:0] pin_filtered
);
    // ----------------------------------------
    // Pad and register port relations
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Previous edge was out of reset
    sequence run_on;
        $past(arst_n);
    endsequence
    sequence no_read;
        !reg_rd;
    endsequence
    in_drive_off_a: assert property (run_on |-> ~|(pad_oe & ~$past(pin_dir_out)))
        else $error("pad driven on an input pin");
    in_buf_a: assert property (run_on |-> pad_in_buf_en == ~$past(pin_dir_out))
        else $error("input buffer enable wrong");
    pull_up_a: assert property (
        run_on |-> pad_pull_up_en == $past(pull_enable & pull_select_up))
        else $error("pull-up enable wrong");
    pull_dn_a: assert property (
        run_on |-> pad_pull_dn_en == $past(pull_enable & ~pull_select_up))
        else $error("pull-down enable wrong");
    low_drive_a: assert property (
        run_on |-> ~|((pad_out | ~pad_oe) & $past(pin_dir_out & ~pin_out_level)))
        else $error("output pin not driven low");
    high_stage_a: assert property (
        run_on |-> ~|((pad_out ^ pad_oe) & $past(pin_dir_out & pin_out_level)))
        else $error("high output stage inconsistent");
    out_bypass_a: assert property (
        run_on |-> ~|((pin_filtered ^ $past(pad_in)) & $past(pin_dir_out)))
        else $error("output pin passed through debounce");
    raw_ports_a: assert property (
        run_on |-> pin_filtered[PIN_N-1:DB_PINS] == $past(pad_in[PIN_N-1:DB_PINS]))
        else $error("port 2 pin filtered");
    rdata_hold_a: assert property (no_read |=> $stable(reg_rdata))
        else $error("read data changed without a read");
endmodule
bind gpio_pin_config_debounce gpio_pin_sva chk_u (.core_clk, .arst_n, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .pin_dir_out, .pin_out_level, .pull_enable, .pull_select_up, .pad_in,
    .pad_out, .pad_oe, .pad_pull_up_en, .pad_pull_dn_en, .pad_in_buf_en, .pin_filtered);

/* timebase_osc.sv */
// External time-base oscillator model for the debounce reference pin.
// Assumes run is held by the bench; output rests low while stopped.
module timebase_osc #(parameter int HALF = 4) (
    input  wire logic core_clk,
    input  wire logic run,
    output logic      osc
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial osc = 1'b0;
    always @(posedge core_clk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (!run)
            osc <= #1 1'b0;
        else if (cnt == HALF - 1)
            osc <= #1 ~osc;
    end
endmodule

/* test_gpio_pin_config_debounce.sv */
// Self-checking bench for the GPIO pin block with a time-base oscillator model.
// Assumes byte register port, one-cycle registered pad outputs.
module test_gpio_pin_config_debounce
    import gpio_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, osc, osc_run = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [PIN_N-1:0] pin_dir_out = '0, pin_out_level = 24'h0f0f0f, pad_in, pad_out, pad_oe;
    logic [PIN_N-1:0] pull_enable = 24'hf0f0f0, pull_select_up = 24'hcccccc;
    logic [PIN_N-1:0] pad_pull_up_en, pad_pull_dn_en, pad_in_buf_en, pin_filtered;
    logic [PIN_N-1:1] pad_hi = 23'h5a3c1e;
    int fails = 0, samples_checked = 0, cycles = 0;
    localparam logic [7:0] RW_ADDR [7] = '{ADDR_BANK_DRAIN, ADDR_STAGE_OVR0, ADDR_STAGE_OVR1,
        ADDR_STAGE_OVR2, ADDR_DEBOUNCE_EN0, ADDR_DEBOUNCE_EN1, ADDR_DEBOUNCE_CNT};
    assign pad_in = {pad_hi, osc};
    always #2.5 core_clk = ~core_clk;
    timebase_osc #(.HALF(4)) osc_u (.core_clk(core_clk), .run(osc_run), .osc(osc));
    gpio_pin_config_debounce dut_u (.core_clk, .arst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .pin_dir_out, .pin_out_level, .pull_enable, .pull_select_up, .pad_in,
        .pad_out, .pad_oe, .pad_pull_up_en, .pad_pull_dn_en, .pad_in_buf_en, .pin_filtered);
    // ----------------------------------------
    // Access tasks and checks
    // ----------------------------------------
    task automatic complete_run();
        if (fails == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [PIN_N-1:0] exp, got);
        samples_checked++;
        if (exp !== got) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, d);
        step(1);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        step(1);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, exp);
        step(1);
        reg_rd = 1'b1;
        reg_addr = a;
        step(1);
        reg_rd = 1'b0;
        check("reg_rdata", {16'h0000, exp}, {16'h0000, reg_rdata});
    endtask
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            complete_run();
        end
    end
    initial begin
        step(2);
        reg_wr = 1'b1;
        reg_addr = ADDR_STAGE_OVR0;
        reg_wdata = 8'hff;
        step(3);
        reg_wr = 1'b0;
        arst_n = 1'b1;
        foreach (RW_ADDR[i]) rd(RW_ADDR[i], 8'h00);
        foreach (RW_ADDR[i]) wr(RW_ADDR[i], 8'h29 + 8'(i));
        foreach (RW_ADDR[i]) rd(RW_ADDR[i], (i == 0) ? 8'h01 : 8'h29 + 8'(i));
        wr(ADDR_LIVE_IN0, 8'hff);
        for (int p = 0; p < 3; p++) rd(ADDR_LIVE_IN0 + 8'(p), pad_in[p*8 +: 8]);
        rd(8'h7f, UNMAPPED_RDATA);
        for (int k = 0; k < 4; k++) begin
            pin_dir_out = '0;
            pull_select_up = {PIN_N{k[0]}};
            wr(ADDR_BANK_DRAIN, k[1] ? 8'h07 : 8'h00);
            for (int p = 0; p < 3; p++) wr(ADDR_STAGE_OVR0 + 8'(p), k[0] ? 8'hff : 8'h00);
            pin_dir_out = {PIN_N{1'b1}};
            step(2);
            check("pad_oe", (k[1] == k[0]) ? '1 : ~pin_out_level, pad_oe);
            check("pad_out", (k[1] == k[0]) ? pin_out_level : '0, pad_out);
            check("pad_in_buf_en", '0, pad_in_buf_en);
            check("pad_pull_up_en", pull_enable & pull_select_up, pad_pull_up_en);
            check("pad_pull_dn_en", pull_enable & ~pull_select_up, pad_pull_dn_en);
            rd(ADDR_LIVE_IN1, (k[1] == k[0]) ? pad_in[15:8] : 8'h00);
        end
        pin_dir_out = '0;
        step(2);
        check("pad_oe", '0, pad_oe);
        check("pad_in_buf_en", '1, pad_in_buf_en);
        wr(ADDR_DEBOUNCE_CNT, 8'h02);
        wr(ADDR_DEBOUNCE_EN0, 8'h03);
        pad_hi[1] = 1'b1;
        osc_run = 1'b1;
        step(40);
        pad_hi[1] = 1'b0;
        step(12);
        check("pin_filtered_1", 24'h000001, {23'h0, pin_filtered[1]});
        step(30);
        check("pin_filtered_1", 24'h000000, {23'h0, pin_filtered[1]});
        wr(ADDR_DEBOUNCE_EN0, 8'h02);
        pad_hi[1] = 1'b1;
        step(3);
        check("pin_filtered_1", 24'h000001, {23'h0, pin_filtered[1]});
        wr(ADDR_DEBOUNCE_EN0, 8'h03);
        pin_dir_out[1] = 1'b1;
        pad_hi[1] = 1'b0;
        step(3);
        check("pin_filtered_1", 24'h000000, {23'h0, pin_filtered[1]});
        wr(ADDR_DEBOUNCE_CNT, 8'h05);
        arst_n = 1'b0;
        step(2);
        arst_n = 1'b1;
        rd(ADDR_DEBOUNCE_CNT, 8'h00);
        complete_run();
    end
endmodule
